// File: test/sce_serial_peer.sv
// Behavioural far-end serial device sending and taking 8N1 characters.
`timescale 1ns/100ps
`default_nettype none
module sce_serial_peer (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic tick,
  input wire logic lineIn,
  output logic lineOut,
  input wire logic sendGo,
  input wire logic [7:0] sendByte,
  output logic busy,
  output logic [7:0] gotByte,
  output logic gotStb
);
  // ====================================================================
  // Timing
  // Both directions count the 16x ticks, as a peer on a matched rate.
  task automatic waitTicks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      while (!tick) @(posedge clk_sys);
    end
  endtask
  // ====================================================================
  // Sender and receiver
  initial begin
    lineOut = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (sendGo) begin
        busy <= 1'b1;
        waitTicks(1);
        lineOut <= 1'b0;
        for (int i = 0; i < 8; i++) begin
          waitTicks(16);
          lineOut <= sendByte[i];
        end
        waitTicks(16);
        lineOut <= 1'b1;
        waitTicks(16);
        busy <= 1'b0;
      end
    end
  end
  // A character whose stop sample is low is dropped, not reported.
  initial begin
    gotStb = 1'b0;
    gotByte = 8'h00;
    forever begin
      @(posedge clk_sys);
      gotStb <= 1'b0;
      if (rstn && !lineIn) begin
        waitTicks(8);
        for (int i = 0; i < 8; i++) begin
          waitTicks(16);
          gotByte[i] <= lineIn;
        end
        waitTicks(16);
        gotStb <= lineIn;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/sce_uart_path_properties.sv
// Concurrent checks on the host and serial ports of the data path.
`timescale 1ns/100ps
`default_nettype none
module sce_uart_path_properties
  import sce_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] rdData,
  input wire logic irq,
  input wire logic rxClk16,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic baudClockOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ====================================================================
  // Shadow state
  // Host writes are mirrored here because the checker cannot see inside.
  logic [7:0] scrReg;
  logic [15:0] divReg;
  logic [2:0] maskReg;
  logic fifoReg;
  logic armedReg;
  logic [16:0] gapReg;
  logic [7:0] lowReg;
  // The line lags the transmitter state by one register stage.
  logic baudDly;
  logic divWr;
  assign divWr = wrEn && (addr == OFF_DIVLO || addr == OFF_DIVHI);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scrReg <= SCRATCH_RST;
      divReg <= DIV_RST;
      maskReg <= MASK_RST;
      fifoReg <= 1'b0;
    end else if (wrEn) begin
      if (addr == OFF_SCRATCH) scrReg <= wrData;
      if (addr == OFF_DIVLO) divReg[7:0] <= wrData;
      if (addr == OFF_DIVHI) divReg[15:8] <= wrData;
      if (addr == OFF_MASK) maskReg <= wrData[2:0];
      if (addr == OFF_FCTRL) fifoReg <= wrData[FC_ENABLE];
    end
  end
  // A divisor write restarts the count, so the period check is disarmed
  // until the first pulse after it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gapReg <= 17'h00001;
      armedReg <= 1'b0;
      lowReg <= 8'h00;
      baudDly <= 1'b0;
    end else begin
      baudDly <= baudClockOut;
      gapReg <= (baudClockOut || divWr) ? 17'h00001 : gapReg + 17'h00001;
      armedReg <= !divWr && (baudClockOut || armedReg);
      lowReg <= serialOut ? 8'h00 : lowReg + {7'h00, baudDly};
    end
  end
  // ====================================================================
  // Assertions
  property p_scratch;
    rdEn && addr == OFF_SCRATCH |=> rdData == scrReg;
  endproperty
  a_scratch: assert property (p_scratch)
    else $error("scratch read back differs from last write");
  property p_baud_period;
    baudClockOut && armedReg |-> gapReg == {1'b0, divReg};
  endproperty
  a_baud_period: assert property (p_baud_period)
    else $error("baud pulse spacing differs from divisor");
  property p_baud_reload;
    divReg != 16'h0000 |-> gapReg <= {1'b0, divReg} + 17'h00001;
  endproperty
  a_baud_reload: assert property (p_baud_reload)
    else $error("baud pulse late after divisor write");
  property p_baud_stop;
    divReg == 16'h0000 && gapReg > 17'h00002 |-> !baudClockOut;
  endproperty
  a_baud_stop: assert property (p_baud_stop)
    else $error("baud pulse with zero divisor");
  property p_bit_len;
    $rose(serialOut) |-> lowReg[3:0] == 4'h0 && lowReg != 8'h00;
  endproperty
  a_bit_len: assert property (p_bit_len)
    else $error("low run on serial output not whole bits");
  property p_reset_idle;
    $rose(rstn) |-> serialOut && !irq && !baudClockOut;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_rx_clear;
    rdEn && addr == OFF_DATA && maskReg == 3'h1 && !fifoReg |-> ##2 !irq;
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("receive interrupt stays after data read");
  property p_mask_off;
    wrEn && addr == OFF_MASK && wrData[2:0] == 3'h0 |-> ##2 !irq [*2];
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt high with all sources masked");
  c_frame: cover property ($rose(serialOut));
  c_irq: cover property ($rose(irq));
  c_rx: cover property ($fell(serialIn));
  c_scr: cover property (rdEn && addr == OFF_SCRATCH);
endmodule
bind sce_uart_path sce_uart_path_properties #(.DEPTH(DEPTH)) chk_u (
  .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wrData(wrData),
  .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .irq(irq),
  .rxClk16(rxClk16), .serialIn(serialIn), .serialOut(serialOut),
  .baudClockOut(baudClockOut));
`default_nettype wire

// File: test/sce_uart_path_tb.sv
// Self-checking bench for the serial data path with a far-end peer.
`timescale 1ns/100ps
`default_nettype none
module sce_uart_path_tb
  import sce_pkg::*;
;
  logic clk_sys, rstn, wrEn, rdEn, irq, serialIn, serialOut, baudClk;
  logic sendGo, busy, gotStb;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wrData, rdData, sendByte, gotByte;
  logic [7:0] txq[$];
  int errorCnt, checks;
  // ====================================================================
  // Structure
  // The baud output also feeds the receive clock, so both paths share ticks.
  sce_uart_path #(.DEPTH(FIFO_DEPTH)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .irq(irq),
    .rxClk16(baudClk), .serialIn(serialIn), .serialOut(serialOut),
    .baudClockOut(baudClk));
  sce_serial_peer peer_u (
    .clk_sys(clk_sys), .rstn(rstn), .tick(baudClk), .lineIn(serialOut),
    .lineOut(serialIn), .sendGo(sendGo), .sendByte(sendByte),
    .busy(busy), .gotByte(gotByte), .gotStb(gotStb));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (gotStb) txq.push_back(gotByte);
  // ====================================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic hang(input string n);
    errorCnt++;
    $display("BAD %s expected done seen timeout", n);
    summarize();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk_sys);
    wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input string n,
                    input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk_sys);
    rdEn <= 1'b0;
    #1 chk(n, e, rdData);
  endtask
  // The interrupt output lags a mask write by one register stage.
  task automatic irqIs(input logic e);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq", {7'h00, e}, {7'h00, irq});
  endtask
  task automatic waitTx(input int n);
    for (int i = 0; i < 40000 && txq.size() < n; i++) @(posedge clk_sys);
    if (txq.size() < n) hang("tx count");
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys);
    sendByte <= b;
    sendGo <= 1'b1;
    @(posedge clk_sys);
    sendGo <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 2000 && busy; i++) @(posedge clk_sys);
    if (busy) hang("peer send");
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  // ====================================================================
  // Sequence
  initial begin
    rstn = 1'b0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 4'h0;
    wrData = 8'h00;
    sendGo = 1'b0;
    sendByte = 8'h00;
    errorCnt = 0;
    checks = 0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(OFF_LCTRL, "lctrl", LCTRL_RST);
    rd(OFF_ISTAT, "istat", {5'h00, ISTAT_RST});
    rd(OFF_LSTAT, "lstat", 8'h60);
    rd(OFF_SCRATCH, "scratch", SCRATCH_RST);
    rd(4'hF, "unmapped", 8'h00);
    done("reset");
    wr(OFF_SCRATCH, 8'hA5);
    rd(OFF_SCRATCH, "scratch", 8'hA5);
    wr(OFF_SCRATCH, 8'h5A);
    rd(OFF_LCTRL, "lctrl", LCTRL_RST);
    rd(OFF_ISTAT, "istat", {5'h00, ISTAT_RST});
    rd(OFF_SCRATCH, "scratch", 8'h5A);
    done("scratch");
    wr(OFF_MASK, 8'h02);
    irqIs(1'b1);
    wr(OFF_MASK, 8'h00);
    irqIs(1'b0);
    wr(OFF_MASK, 8'h02);
    irqIs(1'b1);
    wr(OFF_ISTAT, 8'h02);
    irqIs(1'b0);
    rd(OFF_ISTAT, "istat", 8'h00);
    done("interrupt");
    // Generator stopped: the first byte parks in the shifter.
    wr(OFF_DATA, 8'h3C);
    repeat (4) @(posedge clk_sys);
    rd(OFF_ISTAT, "istat", 8'h02);
    wr(OFF_DATA, 8'hC3);
    rd(OFF_ISTAT, "istat", 8'h00);
    irqIs(1'b0);
    wr(OFF_DIVLO, 8'h02);
    waitTx(2);
    chk("tx0", 8'h3C, txq[0]);
    chk("tx1", 8'hC3, txq[1]);
    irqIs(1'b1);
    repeat (64) @(posedge clk_sys);
    wr(OFF_LCTRL, 8'h02);
    wr(OFF_DATA, 8'h35);
    waitTx(3);
    chk("tx7", 8'hB5, txq[2]);
    wr(OFF_LCTRL, LCTRL_RST);
    wr(OFF_DIVLO, 8'h00);
    done("char tx");
    wr(OFF_FCTRL, 8'h01);
    for (int i = 0; i < FIFO_DEPTH + 2; i++) wr(OFF_DATA, 8'(8'h40 + i));
    rd(OFF_LSTAT, "lstat", 8'h00);
    wr(OFF_DIVLO, 8'h02);
    waitTx(FIFO_DEPTH + 4);
    repeat (800) @(posedge clk_sys);
    chk("txcnt", 8'(FIFO_DEPTH + 4), 8'(txq.size()));
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      chk("txfifo", 8'(8'h40 + i), txq[i + 3]);
    end
    rd(OFF_LSTAT, "lstat", 8'h60);
    done("fifo tx");
    wr(OFF_FCTRL, 8'h00);
    wr(OFF_MASK, 8'h01);
    send(8'hA7);
    irqIs(1'b1);
    rd(OFF_DATA, "rxchar", 8'hA7);
    irqIs(1'b0);
    done("char rx");
    wr(OFF_FCTRL, 8'h41);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      send(8'(8'h80 + i));
      if (i == 2) irqIs(1'b0);
      if (i == 3) irqIs(1'b1);
    end
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      rd(OFF_DATA, "rxfifo", 8'(8'h80 + i));
    end
    irqIs(1'b0);
    done("fifo rx");
    summarize();
  end
endmodule
`default_nettype wire

// File: verilog/sce_pkg.sv
// Shared constants of the serial communications element data path.
package sce_pkg;
  // ====================================================================
  // Register map
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_MASK = 4'h1;
  localparam logic [3:0] OFF_ISTAT = 4'h2;
  localparam logic [3:0] OFF_LCTRL = 4'h3;
  localparam logic [3:0] OFF_FCTRL = 4'h4;
  localparam logic [3:0] OFF_LSTAT = 4'h5;
  localparam logic [3:0] OFF_DIVLO = 4'h6;
  localparam logic [3:0] OFF_DIVHI = 4'h7;
  localparam logic [3:0] OFF_SCRATCH = 4'h8;
  // ====================================================================
  // Field positions
  localparam int LC_STOP2 = 2;
  localparam int LC_PAR_EN = 3;
  localparam int LC_PAR_EVEN = 4;
  localparam int LC_BREAK = 6;
  localparam int FC_ENABLE = 0;
  localparam int FC_RX_RST = 1;
  localparam int FC_TX_RST = 2;
  localparam int IS_RX = 0;
  localparam int IS_TX = 1;
  localparam int IS_ERR = 2;
  localparam int LS_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAME = 3;
  localparam int LS_THEMPTY = 5;
  localparam int LS_TEMPTY = 6;
  // ====================================================================
  // Reset values
  localparam logic [7:0] LCTRL_RST = 8'h03;
  localparam logic [7:0] FCTRL_RST = 8'h00;
  localparam logic [2:0] ISTAT_RST = 3'h2;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  // ====================================================================
  // Timing in 16x ticks
  localparam logic [4:0] BIT_TICKS = 5'h10;
  localparam logic [4:0] HALF_TICKS = 5'h08;
  localparam logic [4:0] STOP15_TICKS = 5'h18;
  localparam logic [5:0] STOP2_TICKS = 6'h20;
  localparam int FIFO_DEPTH = 16;
  typedef enum {
    SCE_IDLE, SCE_START, SCE_DATA, SCE_PARITY, SCE_STOP
  } sce_frame_type;
endpackage

// File: verilog/sce_uart_path.sv
// Receive and transmit data path with FIFOs, baud generator, scratch.
//
// Functional notes
// - Receive buffer is a sixteen-byte FIFO.
// - Receiver timed by sixteen-times receive clock.
// - Serial input shifted, assembled, pushed into FIFO.
// - Character mode: receive interrupt on arrival.
// - Character mode: receive interrupt cleared by read.
// - FIFO mode: receive interrupt follows FIFO trigger level setting.
// - Eight-bit scratch register, no side effects.
// - Transmit holding is a sixteen-byte FIFO.
// - Transmitter timed by baud generator output.
// - Load shift register only when it idles.
// - Shift register bits driven on serial output.
// - Character mode: holding-empty interrupt while empty.
// - Character mode: holding-empty cleared by host load.
// - Line control sets framing for both directions.
// - Baud generator divides by sixteen-bit divisor.
// - Divisor byte write reloads the baud counter.
`timescale 1ns/100ps
`default_nettype none
module sce_uart_path
  import sce_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  output logic irq,
  input wire logic rxClk16,
  input wire logic serialIn,
  output logic serialOut,
  output logic baudClockOut
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
  localparam logic [PW:0] ONE_C = (PW+1)'(1);

  // ====================================================================
  // Helpers
  function automatic logic [2:0] lastBit(input logic [7:0] lc);
    lastBit = {1'b0, lc[1:0]} + 3'h4;
  endfunction

  function automatic logic parityOf(input logic [7:0] d,
                                    input logic [7:0] lc);
    logic [7:0] m;
    m = 8'hFF >> (3'h3 - lc[1:0]);
    parityOf = ^(d & m) ^ ~lc[LC_PAR_EVEN];
  endfunction

  // ====================================================================
  // Register state
  logic [7:0] lctrl_reg;
  logic [7:0] fctrl_reg;
  logic [2:0] mask_reg;
  logic [2:0] istat_reg;
  logic [2:0] istat_next;
  logic [15:0] div_reg;
  logic [7:0] scratch_reg;
  logic overrun_reg;
  logic parErr_reg;
  logic frameErr_reg;
  logic [7:0] rdData_reg;
  logic irq_reg;

  logic wrData0;
  logic rdData0;
  logic fifoMode;
  logic [PW:0] capacity;
  logic [PW:0] trigLevel;

  assign wrData0 = wrEn && addr == OFF_DATA;
  assign rdData0 = rdEn && addr == OFF_DATA;
  assign fifoMode = fctrl_reg[FC_ENABLE];
  // Character mode behaves as a one-deep holding register.
  assign capacity = fifoMode ? DEPTH_C : ONE_C;

  always_comb begin
    unique case (fctrl_reg[7:6])
      2'h0: trigLevel = (PW+1)'(1);
      2'h1: trigLevel = (PW+1)'(4);
      2'h2: trigLevel = (PW+1)'(8);
      default: trigLevel = (PW+1)'(14);
    endcase
  end

  // ====================================================================
  // Baud generator
  logic [15:0] baudCnt_reg;
  logic baudClockOut_reg;
  logic divWr;

  assign divWr = wrEn && (addr == OFF_DIVLO || addr == OFF_DIVHI);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_reg <= DIV_RST;
    end else if (wrEn && addr == OFF_DIVLO) begin
      div_reg[7:0] <= wrData;
    end else if (wrEn && addr == OFF_DIVHI) begin
      div_reg[15:8] <= wrData;
    end
  end

  // A zero divisor stops the generator rather than wrapping.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      baudCnt_reg <= DIV_RST;
      baudClockOut_reg <= 1'b0;
    end else begin
      baudClockOut_reg <= 1'b0;
      if (divWr) begin
        baudCnt_reg <= (addr == OFF_DIVLO) ? {div_reg[15:8], wrData}
                                           : {wrData, div_reg[7:0]};
      end else if (div_reg != 16'h0000) begin
        if (baudCnt_reg <= 16'h0001) begin
          baudCnt_reg <= div_reg;
          baudClockOut_reg <= 1'b1;
        end else begin
          baudCnt_reg <= baudCnt_reg - 16'h0001;
        end
      end
    end
  end

  // ====================================================================
  // Control registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lctrl_reg <= LCTRL_RST;
      mask_reg <= MASK_RST;
      scratch_reg <= SCRATCH_RST;
    end else if (wrEn) begin
      if (addr == OFF_LCTRL) lctrl_reg <= wrData;
      if (addr == OFF_MASK) mask_reg <= wrData[2:0];
      if (addr == OFF_SCRATCH) scratch_reg <= wrData;
    end
  end

  // Reset bits self-clear; a mode change flushes both FIFOs.
  logic rxFlush;
  logic txFlush;
  assign rxFlush = wrEn && addr == OFF_FCTRL &&
                   (wrData[FC_RX_RST] || wrData[FC_ENABLE] != fifoMode);
  assign txFlush = wrEn && addr == OFF_FCTRL &&
                   (wrData[FC_TX_RST] || wrData[FC_ENABLE] != fifoMode);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fctrl_reg <= FCTRL_RST;
    end else if (wrEn && addr == OFF_FCTRL) begin
      fctrl_reg <= {wrData[7:6], 5'h00, wrData[FC_ENABLE]};
    end
  end

  // ====================================================================
  // Receive FIFO
  logic [7:0] rxMem [DEPTH];
  logic [PW-1:0] rxWp_reg;
  logic [PW-1:0] rxRp_reg;
  logic [PW:0] rxCount_reg;
  logic rxPush;
  logic [7:0] rxChar;
  logic rxAccept;
  logic rxPop;

  assign rxAccept = rxPush && rxCount_reg < capacity;
  assign rxPop = rdData0 && rxCount_reg != '0;

  always_ff @(posedge clk_sys) begin
    if (rxAccept) rxMem[rxWp_reg] <= rxChar;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxWp_reg <= '0;
      rxRp_reg <= '0;
      rxCount_reg <= '0;
    end else if (rxFlush) begin
      rxWp_reg <= '0;
      rxRp_reg <= '0;
      rxCount_reg <= '0;
    end else begin
      if (rxAccept) rxWp_reg <= rxWp_reg + 1'b1;
      if (rxPop) rxRp_reg <= rxRp_reg + 1'b1;
      rxCount_reg <= rxCount_reg + (PW+1)'(rxAccept)
                     - (PW+1)'(rxPop);
    end
  end

  // ====================================================================
  // Receiver, timed by edges of the 16x receive clock
  sce_frame_type rxState_reg;
  logic rxClkPrev_reg;
  logic rxTick;
  logic [4:0] rxCnt_reg;
  logic [2:0] rxBit_reg;
  logic [7:0] rxShift_reg;
  logic rxParBad_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rxClkPrev_reg <= 1'b0;
    else rxClkPrev_reg <= rxClk16;
  end
  assign rxTick = rxClk16 && !rxClkPrev_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxState_reg <= SCE_IDLE;
      rxCnt_reg <= '0;
      rxBit_reg <= '0;
      rxShift_reg <= '0;
      rxParBad_reg <= 1'b0;
    end else begin
      unique case (rxState_reg)
        SCE_IDLE: begin
          rxCnt_reg <= '0;
          rxBit_reg <= '0;
          rxShift_reg <= '0;
          rxParBad_reg <= 1'b0;
          if (!serialIn) rxState_reg <= SCE_START;
        end
        SCE_START: if (rxTick) begin
          rxCnt_reg <= rxCnt_reg + 5'h01;
          if (rxCnt_reg == HALF_TICKS - 5'h01) begin
            rxCnt_reg <= '0;
            // A start bit gone high by mid-bit was a glitch.
            rxState_reg <= serialIn ? SCE_IDLE : SCE_DATA;
          end
        end
        SCE_DATA: if (rxTick) begin
          rxCnt_reg <= rxCnt_reg + 5'h01;
          if (rxCnt_reg == BIT_TICKS - 5'h01) begin
            rxCnt_reg <= '0;
            rxShift_reg[rxBit_reg] <= serialIn;
            rxBit_reg <= rxBit_reg + 3'h1;
            if (rxBit_reg == lastBit(lctrl_reg)) begin
              rxState_reg <= lctrl_reg[LC_PAR_EN] ? SCE_PARITY
                                                  : SCE_STOP;
            end
          end
        end
        SCE_PARITY: if (rxTick) begin
          rxCnt_reg <= rxCnt_reg + 5'h01;
          if (rxCnt_reg == BIT_TICKS - 5'h01) begin
            rxCnt_reg <= '0;
            rxParBad_reg <= serialIn != parityOf(rxShift_reg, lctrl_reg);
            rxState_reg <= SCE_STOP;
          end
        end
        SCE_STOP: if (rxTick) begin
          rxCnt_reg <= rxCnt_reg + 5'h01;
          if (rxCnt_reg == BIT_TICKS - 5'h01) begin
            rxState_reg <= SCE_IDLE;
          end
        end
      endcase
    end
  end

  assign rxPush = rxState_reg == SCE_STOP && rxTick &&
                  rxCnt_reg == BIT_TICKS - 5'h01;
  assign rxChar = rxShift_reg;

  // ====================================================================
  // Transmit FIFO
  logic [7:0] txMem [DEPTH];
  logic [PW-1:0] txWp_reg;
  logic [PW-1:0] txRp_reg;
  logic [PW:0] txCount_reg;
  logic txAccept;
  logic txPop;
  sce_frame_type txState_reg;

  // Writes to a full holding store are dropped.
  assign txAccept = wrData0 && txCount_reg < capacity;
  assign txPop = txState_reg == SCE_IDLE && txCount_reg != '0;

  always_ff @(posedge clk_sys) begin
    if (txAccept) txMem[txWp_reg] <= wrData;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txWp_reg <= '0;
      txRp_reg <= '0;
      txCount_reg <= '0;
    end else if (txFlush) begin
      txWp_reg <= '0;
      txRp_reg <= '0;
      txCount_reg <= '0;
    end else begin
      if (txAccept) txWp_reg <= txWp_reg + 1'b1;
      if (txPop) txRp_reg <= txRp_reg + 1'b1;
      txCount_reg <= txCount_reg + (PW+1)'(txAccept)
                     - (PW+1)'(txPop);
    end
  end

  // ====================================================================
  // Transmitter, timed by the baud generator output
  logic [4:0] txCnt_reg;
  logic [2:0] txBit_reg;
  logic [7:0] txShift_reg;
  logic [5:0] stopTicks;
  logic serialOut_reg;
  logic txLevel;

  always_comb begin
    if (!lctrl_reg[LC_STOP2]) stopTicks = {1'b0, BIT_TICKS};
    else if (lctrl_reg[1:0] == 2'h0) stopTicks = {1'b0, STOP15_TICKS};
    else stopTicks = STOP2_TICKS;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txState_reg <= SCE_IDLE;
      txCnt_reg <= '0;
      txBit_reg <= '0;
      txShift_reg <= '0;
    end else begin
      unique case (txState_reg)
        SCE_IDLE: begin
          txCnt_reg <= '0;
          txBit_reg <= '0;
          if (txPop) begin
            txShift_reg <= txMem[txRp_reg];
            txState_reg <= SCE_START;
          end
        end
        SCE_START: if (baudClockOut_reg) begin
          txCnt_reg <= txCnt_reg + 5'h01;
          if (txCnt_reg == BIT_TICKS - 5'h01) begin
            txCnt_reg <= '0;
            txState_reg <= SCE_DATA;
          end
        end
        SCE_DATA: if (baudClockOut_reg) begin
          txCnt_reg <= txCnt_reg + 5'h01;
          if (txCnt_reg == BIT_TICKS - 5'h01) begin
            txCnt_reg <= '0;
            txBit_reg <= txBit_reg + 3'h1;
            if (txBit_reg == lastBit(lctrl_reg)) begin
              txState_reg <= lctrl_reg[LC_PAR_EN] ? SCE_PARITY
                                                  : SCE_STOP;
            end
          end
        end
        SCE_PARITY: if (baudClockOut_reg) begin
          txCnt_reg <= txCnt_reg + 5'h01;
          if (txCnt_reg == BIT_TICKS - 5'h01) begin
            txCnt_reg <= '0;
            txState_reg <= SCE_STOP;
          end
        end
        SCE_STOP: if (baudClockOut_reg) begin
          txCnt_reg <= txCnt_reg + 5'h01;
          if ({1'b0, txCnt_reg} == stopTicks - 6'h01) begin
            txState_reg <= SCE_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    unique case (txState_reg)
      SCE_START: txLevel = 1'b0;
      SCE_DATA: txLevel = txShift_reg[txBit_reg];
      SCE_PARITY: txLevel = parityOf(txShift_reg, lctrl_reg);
      default: txLevel = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) serialOut_reg <= 1'b1;
    else serialOut_reg <= txLevel && !lctrl_reg[LC_BREAK];
  end

  // ====================================================================
  // Line status and interrupts
  logic rdLstat;
  logic rxEv;
  logic rxHwClr;
  logic txEv;
  logic errEv;
  logic parEv;
  logic frameEv;
  logic ovrEv;
  logic [2:0] istatEv;
  logic [2:0] istatClr;

  assign rdLstat = rdEn && addr == OFF_LSTAT;
  assign ovrEv = rxPush && !rxAccept;
  assign parEv = rxAccept && rxParBad_reg;
  assign frameEv = rxAccept && !serialIn;
  assign errEv = ovrEv || parEv || frameEv;

  // Error flags clear on a status read; a new error in that cycle wins.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      overrun_reg <= 1'b0;
      parErr_reg <= 1'b0;
      frameErr_reg <= 1'b0;
    end else begin
      overrun_reg <= ovrEv || (overrun_reg && !rdLstat);
      parErr_reg <= parEv || (parErr_reg && !rdLstat);
      frameErr_reg <= frameEv || (frameErr_reg && !rdLstat);
    end
  end

  always_comb begin
    if (fifoMode) begin
      rxEv = rxAccept && rxCount_reg + ONE_C >= trigLevel;
      rxHwClr = rxPop && rxCount_reg <= trigLevel;
      txEv = txPop && txCount_reg == ONE_C;
      rxHwClr = rxHwClr && !rxAccept;
    end else begin
      rxEv = rxAccept;
      rxHwClr = rdData0;
      // Holding empties as its character moves to the shift register.
      txEv = txPop || txFlush;
    end
  end

  assign istatEv = {errEv, txEv, rxEv};
  assign istatClr = ((wrEn && addr == OFF_ISTAT) ? wrData[2:0] : 3'h0)
                    | {1'b0, txAccept, rxHwClr};
  assign istat_next = (istat_reg & ~istatClr) | istatEv;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      istat_reg <= ISTAT_RST;
      irq_reg <= 1'b0;
    end else begin
      istat_reg <= istat_next;
      irq_reg <= |(istat_next & mask_reg);
    end
  end

  // ====================================================================
  // Read port
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= 8'h00;
    end else if (rdEn) begin
      unique case (addr)
        OFF_DATA: rdData_reg <= rxMem[rxRp_reg];
        OFF_MASK: rdData_reg <= {5'h00, mask_reg};
        OFF_ISTAT: rdData_reg <= {5'h00, istat_reg};
        OFF_LCTRL: rdData_reg <= lctrl_reg;
        OFF_FCTRL: rdData_reg <= fctrl_reg;
        OFF_LSTAT: rdData_reg <= {1'b0,
                                  txCount_reg == '0 &&
                                    txState_reg == SCE_IDLE,
                                  txCount_reg == '0, 1'b0,
                                  frameErr_reg, parErr_reg,
                                  overrun_reg, rxCount_reg != '0};
        OFF_DIVLO: rdData_reg <= div_reg[7:0];
        OFF_DIVHI: rdData_reg <= div_reg[15:8];
        OFF_SCRATCH: rdData_reg <= scratch_reg;
        default: rdData_reg <= 8'h00;
      endcase
    end else begin
      rdData_reg <= 8'h00;
    end
  end

  assign rdData = rdData_reg;
  assign irq = irq_reg;
  assign serialOut = serialOut_reg;
  assign baudClockOut = baudClockOut_reg;
endmodule
`default_nettype wire
